//--- design/rig_gen.v
// Remote index generation stage of the block mover
`timescale 1ns/100ps
`include "rig_defines.vh"
module rig_gen (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Programming port from the processing node
  input wire load_i,
  input wire [1:0] kind_i,
  input wire [`RIG_IDX_W-1:0] base_i,
  input wire [`RIG_IDX_W-1:0] step_i,
  input wire [`RIG_PTR_W-1:0] list_ptr_i,
  input wire [`RIG_CNT_W-1:0] count_i,
  input wire [`RIG_IDX_W-1:0] node_mask_i,
  input wire start_i,
  // Status
  output reg busy_o,
  output reg done_o,
  output reg [`RIG_CNT_W-1:0] packet_count_o,
  output reg [`RIG_PTR_W-1:0] list_ptr_o,
  output reg [`RIG_IDX_W-1:0] base_o,
  // Local memory read port for index lists
  output reg mem_req_o,
  output reg [`RIG_GADDR_W-1:0] mem_addr_o,
  input wire mem_gnt_i,
  input wire mem_rvalid_i,
  input wire [4*`RIG_WORD_W-1:0] mem_rdata_i,
  // Stream of indexes to the splitter
  output reg idx_valid_o,
  input wire idx_ready_i,
  output reg [`RIG_IDX_W-1:0] idx_data_o,
  output reg [`RIG_IDX_W-1:0] idx_mask_o
);

  // ---------------------------------------------------------------
  // State and storage
  // ---------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_STRIDE = 3'h1;
  localparam ST_FREQ = 3'h2;
  localparam ST_FWAIT = 3'h3;
  localparam ST_FEMIT = 3'h4;
  localparam ST_DRAIN = 3'h5;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [1:0] kind_r;
  // remote_index_base_reg, remote_step_reg, index_list_pointer_reg
  reg [`RIG_IDX_W-1:0] remote_index_base_reg_r;
  reg [`RIG_IDX_W-1:0] remote_step_reg_r;
  reg [`RIG_PTR_W-1:0] index_list_pointer_reg_r;
  // Packet count plus one extra bit so zero can mean 65,536
  reg [`RIG_CNT_W:0] left_r;
  reg [`RIG_IDX_W-1:0] node_bit_mask_reg_r;
  reg first_r;
  reg [4*`RIG_IDX_W-1:0] group_r;
  reg [2:0] slot_r;
  reg [`RIG_IDX_W-1:0] sum_r;

  wire fifo_ready;
  wire fifo_valid;
  wire [`RIG_IDX_W-1:0] fifo_data;
  wire push;
  wire pop;
  wire list_kind;
  wire [`RIG_IDX_W-1:0] step_term;
  wire [`RIG_IDX_W-1:0] cur_list_idx;
  wire [4*`RIG_IDX_W-1:0] fetched;
  wire last_one;

  // ---------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------
  // kind decode
  assign list_kind = (kind_r == `RIG_KIND_GATHER) |
                     (kind_r == `RIG_KIND_SCATTER);

  assign step_term = first_r ? {`RIG_IDX_W{1'b0}} : remote_step_reg_r;

  // take the low index bits of each 64-bit word in the line
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_word
      assign fetched[g*`RIG_IDX_W +: `RIG_IDX_W] =
        mem_rdata_i[g*`RIG_WORD_W +: `RIG_IDX_W];
    end
  endgenerate

  assign cur_list_idx = group_r[slot_r[1:0]*`RIG_IDX_W +: `RIG_IDX_W];

  // Push only when the FIFO has room; back-pressure stalls generation
  assign push = ((state_r == ST_STRIDE) | (state_r == ST_FEMIT)) &
                fifo_ready;
  // count of up to 65,536 ends on the last index
  assign last_one = (left_r == {{`RIG_CNT_W{1'b0}}, 1'b1});

  // index is opaque here; mask travels with it for the splitter
  always @* begin
    // list index rides the stride path
    if (state_r == ST_FEMIT) begin
      sum_r = remote_index_base_reg_r + cur_list_idx;
    end else begin
      sum_r = remote_index_base_reg_r + step_term;
    end
  end

  // ---------------------------------------------------------------
  // Output FIFO toward the splitter
  // ---------------------------------------------------------------
  rig_fifo #(
    .WIDTH(`RIG_IDX_W),
    .DEPTH(`RIG_FIFO_DEPTH),
    .AW(`RIG_FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(sum_r),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_data),
    .flush_i(1'b0)
  );

  // Registered output stage: load when empty or being taken
  assign pop = fifo_valid & (~idx_valid_o | idx_ready_i);

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idx_valid_o <= 1'b0;
      idx_data_o <= {`RIG_IDX_W{1'b0}};
      idx_mask_o <= {`RIG_IDX_W{1'b0}};
    end else if (pop) begin
      idx_valid_o <= 1'b1;
      idx_data_o <= fifo_data;
      idx_mask_o <= node_bit_mask_reg_r;
    end else if (idx_ready_i) begin
      idx_valid_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // one start runs the whole transfer
        if (start_i) begin
          state_nxt = list_kind ? ST_FREQ : ST_STRIDE;
        end
      end
      ST_STRIDE: begin
        if (push && last_one) begin
          state_nxt = ST_DRAIN;
        end
      end
      ST_FREQ: begin
        if (mem_gnt_i) begin
          state_nxt = ST_FWAIT;
        end
      end
      ST_FWAIT: begin
        if (mem_rvalid_i) begin
          state_nxt = ST_FEMIT;
        end
      end
      ST_FEMIT: begin
        if (push) begin
          // short final line: unused indexes ignored
          // count spent mid-group: drop the rest
          if (last_one) begin
            state_nxt = ST_DRAIN;
          end else if (slot_r == 3'h3) begin
            state_nxt = ST_FREQ;
          end
        end
      end
      ST_DRAIN: begin
        if (!fifo_valid && !idx_valid_o) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Registers of the engine
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ST_IDLE;
      kind_r <= `RIG_KIND_SREAD;
      remote_index_base_reg_r <= {`RIG_IDX_W{1'b0}};
      remote_step_reg_r <= {`RIG_IDX_W{1'b0}};
      index_list_pointer_reg_r <= {`RIG_PTR_W{1'b0}};
      left_r <= {1'b0, `RIG_CNT_RST};
      node_bit_mask_reg_r <= {`RIG_IDX_W{1'b0}};
      first_r <= 1'b0;
      group_r <= {4*`RIG_IDX_W{1'b0}};
      slot_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      case (state_r)
        ST_IDLE: begin
          // Loads are only honoured while idle
          if (load_i) begin
            kind_r <= kind_i;
            remote_index_base_reg_r <= base_i;
            remote_step_reg_r <= step_i;
            index_list_pointer_reg_r <= list_ptr_i;
            left_r <= {1'b0, count_i};
            node_bit_mask_reg_r <= node_mask_i;
          end
          if (start_i) begin
            first_r <= 1'b1;
            if (left_r == {(`RIG_CNT_W+1){1'b0}}) begin
              left_r <= {1'b1, {`RIG_CNT_W{1'b0}}};
            end
          end
        end
        ST_STRIDE: begin
          if (push) begin
            remote_index_base_reg_r <= sum_r;
            first_r <= 1'b0;
            left_r <= left_r - {{`RIG_CNT_W{1'b0}}, 1'b1};
          end
        end
        ST_FREQ: begin
          if (mem_gnt_i) begin
            index_list_pointer_reg_r <=
              index_list_pointer_reg_r + `RIG_PTR_STEP;
          end
        end
        ST_FWAIT: begin
          if (mem_rvalid_i) begin
            group_r <= fetched;
            // aligned list starts at slot zero
            slot_r <= 3'h0;
          end
        end
        ST_FEMIT: begin
          if (push) begin
            left_r <= left_r - {{`RIG_CNT_W{1'b0}}, 1'b1};
            slot_r <= slot_r + 3'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Memory request and status outputs
  // ---------------------------------------------------------------
  // Request held until granted; address is the group of four
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_req_o <= 1'b0;
      mem_addr_o <= {`RIG_GADDR_W{1'b0}};
    end else begin
      mem_req_o <= (state_nxt == ST_FREQ);
      // pointer bits 23:2 pick the line
      if (state_nxt == ST_FREQ && state_r != ST_FREQ) begin
        mem_addr_o <= index_list_pointer_reg_r[`RIG_PTR_W-1:2];
      end
    end
  end

  // Status mirrors; done pulses when the last index leaves
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      packet_count_o <= `RIG_CNT_RST;
      list_ptr_o <= {`RIG_PTR_W{1'b0}};
      base_o <= {`RIG_IDX_W{1'b0}};
    end else begin
      busy_o <= (state_nxt != ST_IDLE);
      done_o <= (state_r == ST_DRAIN) && (state_nxt == ST_IDLE);
      packet_count_o <= left_r[`RIG_CNT_W-1:0];
      list_ptr_o <= index_list_pointer_reg_r;
      base_o <= remote_index_base_reg_r;
    end
  end

endmodule

//--- common/rig_defines.vh
// Constants for the remote index generator of the block mover
`ifndef RIG_DEFINES_VH
`define RIG_DEFINES_VH
// Remote index width in bits
`define RIG_IDX_W 36
// Local memory word width
`define RIG_WORD_W 64
// Index list pointer width (counts 64-bit words)
`define RIG_PTR_W 24
// Packet count register width and its reset value
`define RIG_CNT_W 16
`define RIG_CNT_RST 16'h0000
// Indexes fetched per list read (one cache line)
`define RIG_GROUP 3'h4
// Pointer step after each list read
`define RIG_PTR_STEP 24'h000004
// Local memory group address width (pointer bits 23:2)
`define RIG_GADDR_W 22
// Byte address bit that the pointer's bit 0 stands for
`define RIG_PTR_BYTE_LSB 3
// Transfer kinds
`define RIG_KIND_SREAD 2'h0
`define RIG_KIND_SWRITE 2'h1
`define RIG_KIND_GATHER 2'h2
`define RIG_KIND_SCATTER 2'h3
// FIFO geometry
`define RIG_FIFO_DEPTH 16
`define RIG_FIFO_AW 4
`endif

//--- design/rig_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module rig_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  // Flush (drops all held words)
  input wire flush_i
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  // Honest full and empty from the word count
  assign in_ready_o = (count_r != DEPTH[AW:0]);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o = mem_r[rd_ptr_r];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Storage has no reset; only pointers and count need one
  always @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointer and count update
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

//--- tb/rig_mem_model.sv
// Local memory model that serves index list lines
`timescale 1ns/100ps
`include "rig_defines.vh"
module rig_mem_model (
  // Clock, reset and pace
  input wire clk_i,
  input wire rst_b_i,
  input wire slow_i,
  // Read port
  input wire mem_req_i,
  input wire [`RIG_GADDR_W-1:0] mem_addr_i,
  output reg mem_gnt_o,
  output reg mem_rvalid_o,
  output reg [4*`RIG_WORD_W-1:0] mem_rdata_o
);
  reg [3:0] st_r;
  reg [3:0] lat_r;
  reg pend_r;
  reg [`RIG_GADDR_W-1:0] line_r;
  reg [35:0] v;
  integer j;
  // Grant, latency, data; idle bus toggles so stale data never passes
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= 4'h0;
      lat_r <= 4'h0;
      pend_r <= 1'b0;
      line_r <= 'h0;
      mem_gnt_o <= 1'b0;
      mem_rvalid_o <= 1'b0;
      mem_rdata_o <= 'h0;
    end else begin
      st_r <= st_r + 4'h1;
      mem_rvalid_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      mem_gnt_o <= mem_req_i && !mem_gnt_o && !pend_r &&
                   (!slow_i || st_r[1:0] == 2'h3);
      if (mem_req_i && mem_gnt_o) begin
        pend_r <= 1'b1;
        line_r <= mem_addr_i;
        lat_r <= slow_i ? 4'h5 : 4'h0;
      end else if (pend_r && lat_r != 4'h0) begin
        lat_r <= lat_r - 4'h1;
      end else if (pend_r) begin
        pend_r <= 1'b0;
        mem_rvalid_o <= 1'b1;
        for (j = 0; j < 4; j = j + 1) begin
          v = ({line_r, 2'h0} + j) * 5 + 3;
          mem_rdata_o[j*64 +: 64] <= {28'hfffffff, v};
        end
      end
    end
  end
endmodule

//--- tb/rig_gen_properties.sv
// Port-level assertions for the remote index generator
`timescale 1ns/100ps
`include "rig_defines.vh"
module rig_gen_properties (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Programming and status
  input wire load_i,
  input wire [1:0] kind_i,
  input wire [`RIG_IDX_W-1:0] base_i,
  input wire [`RIG_IDX_W-1:0] step_i,
  input wire [`RIG_IDX_W-1:0] node_mask_i,
  input wire start_i,
  input wire busy_o,
  input wire done_o,
  // Memory and stream
  input wire mem_req_o,
  input wire [`RIG_GADDR_W-1:0] mem_addr_o,
  input wire mem_gnt_i,
  input wire mem_rvalid_i,
  input wire idx_valid_o,
  input wire idx_ready_i,
  input wire [`RIG_IDX_W-1:0] idx_data_o,
  input wire [`RIG_IDX_W-1:0] idx_mask_o
);
  reg [1:0] kind_r;
  reg [35:0] base_r, step_r, mask_r, last_r;
  reg first_r, wait_r, seen_r;
  reg [21:0] gad_r;
  wire take = idx_valid_o && idx_ready_i;
  wire strd = !kind_r[1];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_stall; mem_req_o && !mem_gnt_i; endsequence
  sequence s_end; !busy_o && $past(busy_o) ##1 !done_o; endsequence
  // Shadow of programmed values and list read progress
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      kind_r <= 2'h0; base_r <= 'h0; step_r <= 'h0; mask_r <= 'h0;
      last_r <= 'h0; first_r <= 1'b0; wait_r <= 1'b0; seen_r <= 1'b0;
      gad_r <= 'h0;
    end else begin
      if (load_i && !busy_o) begin
        kind_r <= kind_i; base_r <= base_i; step_r <= step_i;
        mask_r <= node_mask_i;
      end
      if (start_i && !busy_o) first_r <= 1'b1;
      else if (take) first_r <= 1'b0;
      if (take) last_r <= idx_data_o;
      if (start_i && !busy_o) seen_r <= 1'b0;
      else if (mem_req_o && mem_gnt_i) seen_r <= 1'b1;
      if (mem_req_o && mem_gnt_i) begin
        wait_r <= 1'b1; gad_r <= mem_addr_o;
      end else if (mem_rvalid_i) wait_r <= 1'b0;
    end
  end
  a_req_hold: assert property (s_stall |=> mem_req_o && $stable(mem_addr_o))
    else $error("list request dropped or moved before grant");
  a_one_read: assert property (wait_r |-> !mem_req_o)
    else $error("second list read while one outstanding");
  a_line_step: assert property ($rose(mem_req_o) && seen_r |-> mem_addr_o == gad_r + 22'h1)
    else $error("list line did not advance by one group");
  a_stream_hold: assert property (idx_valid_o && !idx_ready_i |=> idx_valid_o && $stable(idx_data_o))
    else $error("index changed while stalled");
  a_first_base: assert property (take && first_r && strd |-> idx_data_o == base_r)
    else $error("first stride index is not the base");
  a_stride_next: assert property (take && !first_r && strd |-> idx_data_o == last_r + step_r)
    else $error("stride index is not previous plus stride");
  a_mask_pass: assert property (idx_valid_o |-> idx_mask_o == mask_r)
    else $error("node mask not passed with index");
  a_stride_nomem: assert property (busy_o && strd |-> !mem_req_o)
    else $error("list read during stride transfer");
  a_done_end: assert property (done_o |-> s_end)
    else $error("done without busy falling or longer than one cycle");
  a_start_busy: assert property (start_i && !busy_o |=> busy_o)
    else $error("start not followed by busy");
endmodule
bind rig_gen rig_gen_properties u_props (.*);

//--- tb/rig_gen_tb.sv
// Self-checking bench for the remote index generator
`timescale 1ns/100ps
`include "rig_defines.vh"
module rig_gen_tb;
  logic clk_i = 1'b0, rst_b_i = 1'b0, load = 1'b0, start = 1'b0;
  logic idx_ready = 1'b1, stall = 1'b0, slow = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [35:0] base = 'h0, step = 'h0, mask = 'h0;
  logic [23:0] ptr = 'h0;
  logic [15:0] cnt = 'h0;
  wire busy_o, done_o, mem_req_o, mem_gnt, mem_rvalid, idx_valid_o;
  wire [15:0] packet_count_o;
  wire [23:0] list_ptr_o;
  wire [35:0] base_o, idx_data_o, idx_mask_o;
  wire [21:0] mem_addr_o;
  wire [255:0] mem_rdata;
  int n_mismatch = 0, checked = 0, cyc_n = 0, n_gnt = 0;
  always #4 clk_i = ~clk_i;
  rig_gen uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .load_i(load),
    .kind_i(kind), .base_i(base), .step_i(step), .list_ptr_i(ptr),
    .count_i(cnt), .node_mask_i(mask), .start_i(start), .busy_o(busy_o),
    .done_o(done_o), .packet_count_o(packet_count_o),
    .list_ptr_o(list_ptr_o), .base_o(base_o), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .mem_gnt_i(mem_gnt), .mem_rvalid_i(mem_rvalid),
    .mem_rdata_i(mem_rdata), .idx_valid_o(idx_valid_o),
    .idx_ready_i(idx_ready), .idx_data_o(idx_data_o),
    .idx_mask_o(idx_mask_o));
  rig_mem_model u_mem (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_i(slow),
    .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .mem_gnt_o(mem_gnt),
    .mem_rvalid_o(mem_rvalid), .mem_rdata_o(mem_rdata));
  // Splitter side stalls every other cycle when asked, cycle limit
  always @(negedge clk_i) idx_ready <= !stall | cyc_n[0];
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (mem_req_o && mem_gnt) n_gnt <= n_gnt + 1;
    if (cyc_n == 90000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [35:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic prog(input [1:0] k, input [35:0] b, s, input [23:0] p,
                      input [15:0] c);
    @(negedge clk_i);
    load = 1'b1; kind = k; base = b; step = s; ptr = p; cnt = c;
    mask = 36'h0_00ff_f000 ^ b;
    n_gnt = 0;
    @(negedge clk_i);
    load = 1'b0;
    start = 1'b1;
    @(negedge clk_i);
    start = 1'b0;
  endtask
  // Takes n indexes; expected from stride law or list contents
  task automatic collect(input [35:0] b, s, input lst, input [23:0] p,
                         input int n);
    int i, w;
    logic [35:0] e;
    i = 0;
    w = 0;
    while (i < n && w < 2000) begin
      @(posedge clk_i);
      if (idx_valid_o === 1'b1 && idx_ready === 1'b1) begin
        e = lst ? b + (p + i) * 5 + 3 : b + s * i;
        chk("idx_data_o", e, idx_data_o);
        i++;
        w = 0;
      end else w++;
    end
    chk("index count", n, i);
    w = 0;
    while (done_o !== 1'b1 && w < 200) begin
      @(posedge clk_i);
      w++;
    end
    chk("done_o", 1'b1, done_o);
    chk("busy_o", 1'b0, busy_o);
    chk("packet_count_o", 16'h0000, packet_count_o);
  endtask
  task automatic t_stride(input [1:0] k, input [35:0] b, s,
                          input [15:0] c, input int n);
    prog(k, b, s, 24'h0, c);
    collect(b, s, 1'b0, 24'h0, n);
  endtask
  task automatic t_list(input [1:0] k, input [35:0] b, input [23:0] p,
                        input [15:0] c, input int g);
    prog(k, b, 36'h0_0000_0007, p, c);
    collect(b, 36'h0, 1'b1, p, c);
    chk("base_o", b, base_o);
    chk("list_ptr_o", p + 4 * g, list_ptr_o);
    chk("grants", g, n_gnt);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'b1;
    stall = 1'b1;
    t_stride(2'h0, 36'h0_0000_0010, 36'h0_0000_0003, 16'h0005, 5);
    t_stride(2'h1, 36'hf_ffff_fffe, 36'h0_0000_0001, 16'h0003, 3);
    stall = 1'b0;
    // list starts sit on a line boundary
    t_list(2'h2, 36'h1_0000_0000, 24'h000104, 16'h0006, 2);
    slow = 1'b1;
    stall = 1'b1;
    t_list(2'h3, 36'h0, 24'h000200, 16'h0004, 1);
    stall = 1'b0;
    t_stride(2'h0, 36'h0, 36'h0_0000_0001, 16'h0000, 65536);
    wrap_up();
  end
endmodule
